/* core/aio_bus_ctrl.sv */
// Purpose: host bus control of an 8-bit analog i/o device
// Assumes: bus pins asynchronous to clk_sys, two-stage synchronised
// Notes: analog parts are modelled as sample/result/dac words
`timescale 1ns/100ps
`include "aio_consts.svh"

module aio_bus_ctrl #(
   parameter int DATA_W = 8,
   parameter int CONV_CYC = `AIO_CONV_CYC
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic convert_trigger_n,
   input wire logic dac_select,
   input wire logic read_start_mode,
   input wire logic span_select,
   input wire logic negative_supply_level,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe,
   output logic conversion_active_n,
   output logic done_flag_n,
   output logic [DATA_W-1:0] dac_a_code,
   output logic [DATA_W-1:0] dac_b_code,
   output logic track_hold,
   output logic [1:0] range_code,
   output aio_pkg::aio_format_t data_format,
   input wire logic [DATA_W-1:0] analog_sample,
   input wire logic [3:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   output logic irq
);
   import aio_pkg::*;

   localparam int CW = $clog2(CONV_CYC + 1);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0] cs_s;
      logic [3:0] rd_s;
      logic [3:0] wr_s;
      logic [3:0] st_s;
      logic [1:0] sel_s;
      logic [1:0] mode_s;
      logic [1:0] span_s;
      logic [1:0] sup_s;
      logic [DATA_W-1:0] din_s1;
      logic [DATA_W-1:0] din_s2;
      logic [DATA_W-1:0] ana_s1;
      logic [DATA_W-1:0] ana_s2;
      aio_conv_state_t st;
      logic [CW-1:0] cnt;
      logic [DATA_W-1:0] hold;
      logic [DATA_W-1:0] result;
      logic [DATA_W-1:0] dac_a;
      logic [DATA_W-1:0] dac_b;
      logic [DATA_W-1:0] dout;
      logic oe;
      logic active_n;
      logic done_n;
      logic th;
      logic [1:0] rng;
      aio_format_t fmt;
      logic [`AIO_ST_W-1:0] status;
      logic [`AIO_ST_W-1:0] mask;
      logic [DATA_W-1:0] rdata;
      logic irq;
   } aio_state_t;

   aio_state_t state_reg;
   aio_state_t state_next;

   // convert offset binary from the converter to the bus format
   function automatic logic [DATA_W-1:0] to_bus(
      input logic [DATA_W-1:0] code,
      input aio_format_t fmt
   );
      to_bus = (fmt == AIO_FMT_TWOS) ? {~code[DATA_W-1], code[DATA_W-2:0]}
                                     : code;
   endfunction : to_bus

   // edge detect on stages 2 and 3 of a pin synchroniser
   function automatic logic went_high(input logic [3:0] s);
      went_high = ~s[2] & s[1];
   endfunction : went_high

   function automatic logic went_low(input logic [3:0] s);
      went_low = s[2] & ~s[1];
   endfunction : went_low

   logic cs_now;
   logic rd_now;
   logic rd_fall;
   logic rd_rise;
   logic cs_rise;
   logic wr_rise;
   logic st_fall;
   logic start;
   logic [`AIO_ST_W-1:0] ev;
   logic [DATA_W-1:0] wbus;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      // ------------------------------------------------------------
      // pin synchronisers; stage 1 is read only by stage 2
      // ------------------------------------------------------------
      state_next.cs_s = {state_reg.cs_s[2:0], chip_select_n};
      state_next.rd_s = {state_reg.rd_s[2:0], read_strobe_n};
      state_next.wr_s = {state_reg.wr_s[2:0], write_strobe_n};
      state_next.st_s = {state_reg.st_s[2:0], convert_trigger_n};
      state_next.sel_s = {state_reg.sel_s[0], dac_select};
      state_next.mode_s = {state_reg.mode_s[0], read_start_mode};
      state_next.span_s = {state_reg.span_s[0], span_select};
      state_next.sup_s = {state_reg.sup_s[0], negative_supply_level};
      state_next.din_s1 = data_in;
      state_next.din_s2 = state_reg.din_s1;
      state_next.ana_s1 = analog_sample;
      state_next.ana_s2 = state_reg.ana_s1;

      // ------------------------------------------------------------
      // edge detect
      // ------------------------------------------------------------
      cs_now = ~state_reg.cs_s[1];
      rd_now = ~state_reg.rd_s[1];
      rd_fall = went_low(state_reg.rd_s);
      rd_rise = went_high(state_reg.rd_s);
      cs_rise = went_high(state_reg.cs_s);
      wr_rise = went_high(state_reg.wr_s);
      // trigger is not gated by chip select
      st_fall = went_low(state_reg.st_s);
      wbus = state_reg.din_s2;
      // starts while busy are dropped by the idle-only decode
      start = st_fall
              | (rd_fall & cs_now & state_reg.mode_s[1]);
      ev = '0;

      // ------------------------------------------------------------
      // span/supply to one range shared by adc and dacs
      // ------------------------------------------------------------
      state_next.rng = {state_reg.sup_s[1],
                        state_reg.span_s[1]};
      state_next.fmt = state_reg.sup_s[1] ? AIO_FMT_TWOS
                                          : AIO_FMT_BINARY;

      // ------------------------------------------------------------
      // conversion sequence
      // ------------------------------------------------------------
      case (state_reg.st)
         AIO_IDLE: begin
            state_next.th = 1'b1;
            if (start) begin
               // sample frozen a cycle before conversion_active_n falls
               state_next.hold = state_reg.ana_s2;
               state_next.th = 1'b0;
               state_next.st = AIO_TRACK;
               ev[`AIO_ST_START] = 1'b1;
            end
         end
         AIO_TRACK: begin
            state_next.active_n = 1'b0;
            state_next.cnt = CW'(CONV_CYC - 1);
            state_next.st = AIO_CONV;
         end
         AIO_CONV: begin
            if (state_reg.cnt == '0) begin
               state_next.active_n = 1'b1;
               state_next.result = state_reg.hold;
               state_next.done_n = 1'b0;
               state_next.th = 1'b1;
               state_next.st = AIO_IDLE;
               ev[`AIO_ST_DONE] = 1'b1;
            end else begin
               state_next.cnt = state_reg.cnt - CW'(1);
            end
         end
         default: begin
            state_next.st = AIO_IDLE;
         end
      endcase

      // ------------------------------------------------------------
      // completion flag release; a new completion wins
      // ------------------------------------------------------------
      // releasing in the completion cycle would lose the new result
      if ((cs_rise | rd_rise) && !ev[`AIO_ST_DONE]) begin
         state_next.done_n = 1'b1;
      end

      // ------------------------------------------------------------
      // read drive while both strobes low
      // ------------------------------------------------------------
      // drive follows the synced strobes, so it lags the pins
      state_next.oe = cs_now & rd_now;
      state_next.dout = to_bus(state_reg.result, state_reg.fmt);

      // ------------------------------------------------------------
      // dac load on rising write strobe
      // ------------------------------------------------------------
      if (wr_rise && cs_now) begin
         if (state_reg.sel_s[1]) begin
            state_next.dac_b = wbus;
         end else begin
            state_next.dac_a = wbus;
         end
         ev[`AIO_ST_DACW] = 1'b1;
      end

      // ------------------------------------------------------------
      // local register port
      // ------------------------------------------------------------
      state_next.rdata = '0;
      if (reg_rd) begin
         case (reg_addr)
            `AIO_OFF_STATUS: state_next.rdata = DATA_W'(state_reg.status);
            `AIO_OFF_MASK: state_next.rdata = DATA_W'(state_reg.mask);
            `AIO_OFF_INFO: state_next.rdata = DATA_W'({state_reg.fmt,
               state_reg.rng, ~state_reg.done_n, ~state_reg.active_n});
            `AIO_OFF_RESULT: state_next.rdata = state_reg.result;
            `AIO_OFF_DACA: state_next.rdata = state_reg.dac_a;
            `AIO_OFF_DACB: state_next.rdata = state_reg.dac_b;
            default: state_next.rdata = '0;
         endcase
      end
      if (reg_wr && reg_addr == `AIO_OFF_MASK) begin
         state_next.mask = reg_wdata[`AIO_ST_W-1:0];
      end
      if (reg_wr && reg_addr == `AIO_OFF_STATUS) begin
         state_next.status = (state_reg.status & ~reg_wdata[`AIO_ST_W-1:0])
                             | ev;
      end else begin
         state_next.status = state_reg.status | ev;
      end
      state_next.irq = |(state_next.status & state_next.mask);
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
         // pins reset to idle high so no false edge follows reset
         state_reg.cs_s <= 4'hf;
         state_reg.rd_s <= 4'hf;
         state_reg.wr_s <= 4'hf;
         state_reg.st_s <= 4'hf;
         state_reg.st <= AIO_IDLE;
         state_reg.dac_a <= `AIO_DAC_RST;
         state_reg.dac_b <= `AIO_DAC_RST;
         state_reg.active_n <= 1'b1;
         state_reg.done_n <= 1'b1;
         state_reg.th <= 1'b1;
         state_reg.mask <= `AIO_MASK_RST;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign data_out = state_reg.dout;
   assign data_oe = state_reg.oe;
   assign conversion_active_n = state_reg.active_n;
   assign done_flag_n = state_reg.done_n;
   assign dac_a_code = state_reg.dac_a;
   assign dac_b_code = state_reg.dac_b;
   assign track_hold = state_reg.th;
   assign range_code = state_reg.rng;
   assign data_format = state_reg.fmt;
   assign reg_rdata = state_reg.rdata;
   assign irq = state_reg.irq;
endmodule : aio_bus_ctrl

/* core/aio_consts.svh */
// Purpose: constants of the analog i/o bus control block
// Assumes: 50 MHz clk_sys
// Notes: offsets, field positions, reset values, timing counts
`ifndef AIO_CONSTS_SVH
`define AIO_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets of the local control port
// ----------------------------------------------------------------
`define AIO_OFF_STATUS 4'h0
`define AIO_OFF_MASK 4'h1
`define AIO_OFF_INFO 4'h2
`define AIO_OFF_RESULT 4'h3
`define AIO_OFF_DACA 4'h4
`define AIO_OFF_DACB 4'h5
`define AIO_OFF_CONVNS 4'h6

// ----------------------------------------------------------------
// status bit positions
// ----------------------------------------------------------------
`define AIO_ST_DONE 0
`define AIO_ST_START 1
`define AIO_ST_DACW 2
`define AIO_ST_W 3

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define AIO_DAC_RST 8'h00
`define AIO_MASK_RST 3'h0
`define AIO_CLK_NS 20
`define AIO_CONV_NS 2000
`define AIO_CONV_CYC ((`AIO_CONV_NS + `AIO_CLK_NS - 1) / `AIO_CLK_NS)

`endif

/* core/aio_pkg.sv */
// Purpose: types of the analog i/o bus control block
// Assumes: constants come from aio_consts.svh
// Notes: none
package aio_pkg;
   typedef enum logic [1:0] {
      AIO_IDLE,
      AIO_TRACK,
      AIO_CONV
   } aio_conv_state_t;

   typedef enum logic {
      AIO_FMT_BINARY,
      AIO_FMT_TWOS
   } aio_format_t;
endpackage : aio_pkg

/* verif/aio_bus_ctrl_chk.sv */
// Purpose: port assertions of aio_bus_ctrl
// Assumes: one clock, pins synchronised inside
// Notes: bound at the foot of this file
`timescale 1ns/100ps
module aio_bus_ctrl_chk
   import aio_pkg::*;
#(
   parameter int CONV_CYC = 100
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic chip_select_n,
   input wire logic read_strobe_n,
   input wire logic convert_trigger_n,
   input wire logic read_start_mode,
   input wire logic span_select,
   input wire logic negative_supply_level,
   input wire logic data_oe,
   input wire logic conversion_active_n,
   input wire logic done_flag_n,
   input wire logic [7:0] dac_a_code,
   input wire logic [7:0] dac_b_code,
   input wire logic track_hold,
   input wire logic [1:0] range_code,
   input wire aio_pkg::aio_format_t data_format
);
   int low_cnt;
   // cycles spent converting
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         low_cnt <= 0;
      else
         low_cnt <= conversion_active_n ? 0 : low_cnt + 1;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_idle; conversion_active_n && track_hold; endsequence
   sequence s_bus_off; (chip_select_n && read_strobe_n) [*6]; endsequence
   sequence s_cs_off; chip_select_n [*8]; endsequence
   sequence s_rd_on; (!chip_select_n && !read_strobe_n) [*5]; endsequence
   sequence s_cfg;
      ($stable(negative_supply_level) && $stable(span_select)) [*5];
   endsequence
   property p_trig;
      $fell(convert_trigger_n) ##0 s_idle |-> ##[2:5] !conversion_active_n;
   endproperty
   property p_rd_start;
      read_start_mode && !chip_select_n && $fell(read_strobe_n) ##0 s_idle
         |-> ##[2:5] !conversion_active_n;
   endproperty
   property p_hold;
      $fell(conversion_active_n) |-> !track_hold && !$past(track_hold);
   endproperty
   property p_len;
      $rose(conversion_active_n)
         |-> low_cnt >= CONV_CYC - 1 && low_cnt <= CONV_CYC + 1;
   endproperty
   property p_done;
      $rose(conversion_active_n) |-> !done_flag_n;
   endproperty
   property p_clr;
      !done_flag_n && $rose(read_strobe_n) |-> ##[1:5] done_flag_n;
   endproperty
   property p_keep; s_bus_off ##0 !done_flag_n |=> !done_flag_n; endproperty
   property p_no_cs;
      s_cs_off |=> !data_oe && $stable(dac_a_code) && $stable(dac_b_code);
   endproperty
   property p_oe; s_rd_on |-> data_oe; endproperty
   property p_fmt;
      s_cfg |-> data_format == aio_format_t'(negative_supply_level)
         && range_code == {negative_supply_level, span_select};
   endproperty
   a_trig: assert property (p_trig)
      else $error("no start");
   a_rd_start: assert property (p_rd_start)
      else $error("no start");
   a_hold: assert property (p_hold)
      else $error("late hold");
   a_len: assert property (p_len)
      else $error("bad length");
   a_done: assert property (p_done)
      else $error("no done");
   a_clr: assert property (p_clr)
      else $error("done kept");
   a_keep: assert property (p_keep)
      else $error("done lost");
   a_no_cs: assert property (p_no_cs)
      else $error("unselected");
   a_oe: assert property (p_oe)
      else $error("no drive");
   a_fmt: assert property (p_fmt)
      else $error("bad format");
endmodule : aio_bus_ctrl_chk

bind aio_bus_ctrl aio_bus_ctrl_chk #(.CONV_CYC(CONV_CYC)) u_chk (
   .clk_sys(clk_sys), .rst_n(rst_n), .chip_select_n(chip_select_n),
   .read_strobe_n(read_strobe_n), .convert_trigger_n(convert_trigger_n),
   .read_start_mode(read_start_mode), .span_select(span_select),
   .negative_supply_level(negative_supply_level), .data_oe(data_oe),
   .conversion_active_n(conversion_active_n), .done_flag_n(done_flag_n),
   .dac_a_code(dac_a_code), .dac_b_code(dac_b_code),
   .track_hold(track_hold), .range_code(range_code),
   .data_format(data_format));

/* verif/aio_host.sv */
// Purpose: host microprocessor on the parallel pins
// Assumes: pins change just after a rising edge
// Notes: released data bus shows the inverse
`timescale 1ns/100ps
module aio_host (
   input wire logic clk_sys,
   output logic chip_select_n,
   output logic read_strobe_n,
   output logic write_strobe_n,
   output logic convert_trigger_n,
   output logic dac_select,
   output logic [7:0] data_in
);
   initial begin
      {chip_select_n, read_strobe_n, write_strobe_n} = 3'h7;
      convert_trigger_n = 1'b1;
      dac_select = 1'b0;
      data_in = 8'h00;
   end
   task automatic wr_dac(input logic s, input logic [7:0] d, input logic c);
      @(posedge clk_sys);
      dac_select <= s;
      data_in <= d;
      chip_select_n <= c;
      write_strobe_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      write_strobe_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chip_select_n <= 1'b1;
      data_in <= ~d;
   endtask : wr_dac
   task automatic rd_res();
      @(posedge clk_sys);
      chip_select_n <= 1'b0;
      read_strobe_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      {chip_select_n, read_strobe_n} <= 2'h3;
   endtask : rd_res
   task automatic trig();
      @(posedge clk_sys);
      convert_trigger_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      convert_trigger_n <= 1'b1;
   endtask : trig
endmodule : aio_host

/* verif/tb_aio_bus_ctrl.sv */
// Purpose: self-checking bench of aio_bus_ctrl
// Assumes: conversion shortened to 20 cycles
// Notes: monitor pops expected values from queues
`timescale 1ns/100ps
module tb_aio_bus_ctrl;
   import aio_pkg::*;
   logic clk_sys, rst_n, read_start_mode, span_select, nsup, reg_wr, reg_rd;
   logic cs_n, rd_n, wr_n, trig_n, dsel, oe, act_n, done_n, th, irq;
   logic rd_q, oe_q, oe_q2;
   logic [7:0] din, dout, dac_a, dac_b, smp, wdat, rdat, expv, prev;
   logic [3:0] addr;
   logic [1:0] rng;
   aio_format_t fmt;
   logic [7:0] q_reg[$], q_pin[$];
   logic [7:0] dac_exp[2];
   int n_fail, comparisons, k;
   aio_bus_ctrl #(.CONV_CYC(20)) u_aio_bus_ctrl (.clk_sys(clk_sys),
      .rst_n(rst_n), .clk_en(1'b1), .chip_select_n(cs_n),
      .read_strobe_n(rd_n), .write_strobe_n(wr_n), .convert_trigger_n(trig_n),
      .dac_select(dsel), .read_start_mode(read_start_mode),
      .span_select(span_select), .negative_supply_level(nsup),
      .data_in(din), .data_out(dout), .data_oe(oe),
      .conversion_active_n(act_n), .done_flag_n(done_n), .dac_a_code(dac_a),
      .dac_b_code(dac_b), .track_hold(th), .range_code(rng),
      .data_format(fmt), .analog_sample(smp), .reg_addr(addr),
      .reg_wdata(wdat), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(rdat), .irq(irq));
   aio_host u_aio_host (.clk_sys(clk_sys), .chip_select_n(cs_n),
      .read_strobe_n(rd_n), .write_strobe_n(wr_n), .convert_trigger_n(trig_n),
      .dac_select(dsel), .data_in(din));
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [7:0] e, g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic end_of_test();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic reg_acc(input logic w, input logic [3:0] a, logic [7:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdat <= d;
      {reg_wr, reg_rd} <= {w, !w};
      if (!w)
         q_reg.push_back(d);
      @(posedge clk_sys);
      {reg_wr, reg_rd} <= 2'h0;
   endtask : reg_acc
   task automatic wait_done();
      for (k = 0; k < 99 && done_n !== 1'b1; k++)
         @(posedge clk_sys);
      for (k = 0; k < 99 && done_n !== 1'b0; k++)
         @(posedge clk_sys);
      chk("done_flag_n", 8'h00, {7'h0, done_n});
   endtask : wait_done
   // ----------
   // monitor
   // ----------
   always @(posedge clk_sys) begin
      if (rd_q)
         chk("reg_rdata", q_reg.pop_front(), rdat);
      if (oe && oe_q && !oe_q2)
         chk("data_out", q_pin.pop_front(), dout);
      rd_q <= reg_rd;
      oe_q <= oe;
      oe_q2 <= oe_q;
   end
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_fail++;
      end_of_test();
   end
   initial begin
      {rst_n, read_start_mode, reg_wr, reg_rd} = 4'h0;
      {addr, wdat, n_fail, comparisons} = '0;
      k = $urandom(32'hdf16);
      span_select = 1'($urandom);
      nsup = 1'($urandom);
      smp = 8'($urandom);
      repeat (10) @(posedge clk_sys);
      chk("dac_a_code", 8'h00, dac_a);
      chk("dac_b_code", 8'h00, dac_b);
      chk("done_flag_n", 8'h01, {7'h0, done_n});
      rst_n <= 1'b1;
      reg_acc(1'b1, 4'h1, 8'h01);
      for (int i = 0; i < 2; i++) begin
         expv = 8'($urandom);
         dac_exp[i] = expv;
         u_aio_host.wr_dac(1'(i), expv, 1'b0);
         u_aio_host.wr_dac(1'(i), ~expv, 1'b1);
         chk("dac_code", expv, i ? dac_b : dac_a);
      end
      chk("irq", 8'h00, {7'h0, irq});
      for (int m = 0; m < 2; m++) begin
         reg_acc(1'b1, 4'h0, 8'h01);
         @(posedge clk_sys);
         chk("irq", 8'h00, {7'h0, irq});
         read_start_mode <= 1'(m);
         smp <= 8'($urandom);
         @(posedge clk_sys);
         expv = smp ^ {nsup, 7'h00};
         if (m == 0)
            u_aio_host.trig();
         else begin
            q_pin.push_back(prev);
            u_aio_host.rd_res();
         end
         for (k = 0; k < 20 && act_n !== 1'b0; k++)
            @(posedge clk_sys);
         smp <= ~smp;
         wait_done();
         chk("irq", 8'h01, {7'h0, irq});
         q_pin.push_back(expv);
         u_aio_host.rd_res();
         prev = expv;
      end
      wait_done();
      reg_acc(1'b0, 4'h3, smp);
      reg_acc(1'b0, 4'h2,
         {3'h0, nsup, nsup, span_select, 2'h2});
      reg_acc(1'b0, 4'h4, dac_exp[0]);
      reg_acc(1'b0, 4'h5, dac_exp[1]);
      reg_acc(1'b0, 4'h0, 8'h07);
      reg_acc(1'b1, 4'h0, 8'h07);
      reg_acc(1'b0, 4'h0, 8'h00);
      reg_acc(1'b0, 4'h1, 8'h01);
      reg_acc(1'b0, 4'hf, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk("irq", 8'h00, {7'h0, irq});
      rst_n <= 1'b0;
      @(posedge clk_sys);
      chk("done_flag_n", 8'h01, {7'h0, done_n});
      chk("dac_a_code", 8'h00, dac_a);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      end_of_test();
   end
endmodule : tb_aio_bus_ctrl
